/* src/vtpc_pkg.sv */
// Shared constants and carrier types for the video test pattern control block.
// Assumes an 8-bit register port and a single 100 MHz clock.
package vtpc_pkg;
    localparam logic [7:0] PAT_CTRL_OFS = 8'h64;
    localparam logic [7:0] PAT_CFG_OFS = 8'h65;
    localparam logic [7:0] IND_INDEX_OFS = 8'h66;
    localparam logic [7:0] IND_DATA_OFS = 8'h67;
    localparam logic [7:0] PAT_CTRL_RST = 8'h10;
    localparam logic [7:0] PAT_CFG_RST = 8'h00;
    localparam logic [7:0] IND_INDEX_RST = 8'h00;
    // Bit positions of the configuration register and the control register enable bit.
    localparam int CFG_BITS18 = 4;
    localparam int CFG_EXTCLK = 3;
    localparam int CFG_TSEL = 2;
    localparam int CFG_INVERT = 1;
    localparam int CFG_SCROLL = 0;
    localparam int CTRL_ENABLE = 0;
    // Indirect register indices.
    localparam int IND_FTC = 0;
    localparam int IND_HTOT = 1;
    localparam int IND_VTOT = 3;
    localparam int IND_HACT = 5;
    localparam int IND_VACT = 7;
    localparam int IND_HSW = 9;
    localparam int IND_VSW = 10;
    localparam int IND_HBP = 11;
    localparam int IND_VBP = 12;
    localparam int IND_SYNC = 13;
    localparam int IND_MASK = 14;
    localparam int IND_DEPTH = 16;
    // Reset image of the indirect space, index 15 in the top byte.
    localparam logic [127:0] IND_RST = {8'h3F, 8'hFE, 8'h00, 8'h02, 8'h02, 8'h01, 8'h02,
        8'h00, 8'h06, 8'h00, 8'h08, 8'h00, 8'h0C, 8'h00, 8'h10, 8'h01};
    localparam int CLK_DIV_DEFAULT = 4;
    localparam logic [23:0] MASK18 = 24'hFCFCFC;

    typedef struct packed {
        logic de;
        logic hs;
        logic vs;
    } vtpc_sync_t;

    typedef struct packed {
        logic [11:0] htot;
        logic [11:0] vtot;
        logic [11:0] hact;
        logic [11:0] vact;
        logic [7:0] hsw;
        logic [7:0] vsw;
        logic [7:0] hbp;
        logic [7:0] vbp;
        logic hs_pol;
        logic vs_pol;
    } vtpc_geom_t;
endpackage : vtpc_pkg

/* src/vtpc_timing.sv */
// Internal raster timing counters for the test pattern generator.
// Assumes tick is a one-cycle pixel strobe on mclk and geometry is held steady.
module vtpc_timing (
    input wire logic mclk, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic run, // Counters run while high.
    input wire logic tick, // Pixel strobe.
    input vtpc_pkg::vtpc_geom_t geom, // Programmed frame geometry.
    output vtpc_pkg::vtpc_sync_t sync_o, // Generated timing.
    output logic frame_start, // Pulse at the first pixel of a frame.
    output logic [11:0] hpos, // Active column.
    output logic [11:0] vpos // Active line.
);
    logic [11:0] hcnt_reg;
    logic [11:0] vcnt_reg;
    logic [11:0] hstart;
    logic [11:0] vstart;
    logic h_act;
    logic v_act;

    assign hstart = 12'(geom.hsw) + 12'(geom.hbp);
    assign vstart = 12'(geom.vsw) + 12'(geom.vbp);
    assign h_act = (hcnt_reg >= hstart) && (hcnt_reg < 12'(hstart + geom.hact));
    assign v_act = (vcnt_reg >= vstart) && (vcnt_reg < 12'(vstart + geom.vact));

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hcnt_reg <= 12'h000;
            vcnt_reg <= 12'h000;
        end else if (!run) begin
            hcnt_reg <= 12'h000;
            vcnt_reg <= 12'h000;
        end else if (tick) begin
            if (hcnt_reg >= 12'(geom.htot - 12'h001)) begin
                hcnt_reg <= 12'h000;
                vcnt_reg <= (vcnt_reg >= 12'(geom.vtot - 12'h001)) ? 12'h000 :
                    12'(vcnt_reg + 12'h001);
            end else begin
                hcnt_reg <= 12'(hcnt_reg + 12'h001);
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync_o <= '0;
            frame_start <= 1'b0;
            hpos <= 12'h000;
            vpos <= 12'h000;
        end else begin
            frame_start <= run && tick && (hcnt_reg == 12'h000) && (vcnt_reg == 12'h000);
            if (tick) begin
                sync_o.de <= run && h_act && v_act;
                sync_o.hs <= run && ((hcnt_reg < 12'(geom.hsw)) ^ geom.hs_pol);
                sync_o.vs <= run && ((vcnt_reg < 12'(geom.vsw)) ^ geom.vs_pol);
                hpos <= 12'(hcnt_reg - hstart);
                vpos <= 12'(vcnt_reg - vstart);
            end
        end
    end

    a_hsync_width: assert property (@(posedge mclk) disable iff (rst)
        run && tick && !geom.hs_pol && (hcnt_reg < 12'(geom.hsw)) |=> sync_o.hs)
        else $error("internal hsync missing inside programmed width");
endmodule : vtpc_timing

/* src/vtpc_top.sv */
// Video test pattern control: register file, indirect window, clock and timing select,
// pattern choice with auto-scroll and colour inversion.
// Assumes host video pins are asynchronous to mclk and far slower than it.
//
// Overview of operation
// - Timing select high: generate own timing from programmed geometry registers.
// - Timing select low: follow host pixel clock, data enable and syncs.
// - Internal timing: clock source bit picks host pixel clock or divided clock.
// - Clock source bit has no effect while external timing is selected.
// - Invert bit high outputs inverted colours, low outputs normal colours.
// - Auto-scroll advances to next enabled pattern after frame count frames.
// - Auto-scroll off keeps the selected pattern unchanged.
// - Indirect data write stores value in the register the index selects.
// - Indirect data read returns the selected register; index keeps its value.
// - Pattern output only while enable bit is set; otherwise disabled.
// - Fixed pattern select field is ignored while auto-scroll is active.
module vtpc_top #(
    parameter int CLK_DIV = vtpc_pkg::CLK_DIV_DEFAULT // Internal pixel divider.
) (
    input wire logic mclk, // System clock, 100 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic reg_wr, // Register write strobe.
    input wire logic reg_rd, // Register read strobe.
    input wire logic [7:0] reg_addr, // Register address.
    input wire logic [7:0] reg_wdata, // Register write data.
    output logic [7:0] reg_rdata, // Register read data, one cycle after reg_rd.
    input wire logic pix_clk, // Host pixel clock pin.
    input wire logic pix_de, // Host data enable pin.
    input wire logic pix_hs, // Host horizontal sync pin.
    input wire logic pix_vs, // Host vertical sync pin.
    output logic [23:0] rgb_o, // Pattern colour.
    output vtpc_pkg::vtpc_sync_t sync_o, // Pattern timing.
    output logic pixel_strobe // Pulse when rgb_o and sync_o update while the enable bit is set.
);
    logic [7:0] ctrl_reg;
    logic [7:0] cfg_reg;
    logic [7:0] index_reg;
    logic [7:0] ind_mem [vtpc_pkg::IND_DEPTH];
    logic [7:0] ind_rd;
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;
    logic pclk_d_reg;
    logic vs_d_reg;
    logic ext_tick;
    logic [7:0] div_reg;
    logic div_tick;
    logic tick;
    logic en;
    logic tsel;
    vtpc_pkg::vtpc_geom_t geom;
    vtpc_pkg::vtpc_sync_t int_sync;
    vtpc_pkg::vtpc_sync_t ext_sync;
    vtpc_pkg::vtpc_sync_t cur_sync;
    logic int_frame;
    logic ext_frame;
    logic frame_start;
    logic [11:0] int_h;
    logic [11:0] int_v;
    logic [11:0] ext_h_reg;
    logic [11:0] ext_v_reg;
    logic de_d_reg;
    logic [11:0] hpos;
    logic [11:0] vpos;
    logic [3:0] cur_pat_reg;
    logic [7:0] frame_cnt_reg;
    logic [15:0] pat_mask;
    logic scroll_due;
    logic [23:0] raw_colour;
    logic [23:0] fin_colour;

    function automatic logic [3:0] next_pattern(input logic [3:0] cur, input logic [15:0] mask);
        logic [3:0] cand;
        logic found;
        next_pattern = cur;
        found = 1'b0;
        for (int i = 1; i < 16; i++) begin
            cand = 4'(cur + 4'(i));
            if (!found && mask[cand]) begin
                next_pattern = cand;
                found = 1'b1;
            end
        end
    endfunction : next_pattern

    // Scaled patterns use the low byte of the position, so a ramp repeats every 256 pixels.
    function automatic logic [23:0] pattern_colour(input logic [3:0] sel,
        input logic [7:0] hl, input logic [7:0] vl);
        case (sel)
            4'h1: pattern_colour = 24'hFFFFFF;
            4'h2: pattern_colour = 24'h000000;
            4'h3: pattern_colour = 24'hFF0000;
            4'h4: pattern_colour = 24'h00FF00;
            4'h5: pattern_colour = 24'h0000FF;
            4'h6: pattern_colour = {hl, hl, hl};
            4'h7: pattern_colour = {hl, 8'h00, 8'h00};
            4'h8: pattern_colour = {8'h00, hl, 8'h00};
            4'h9: pattern_colour = {8'h00, 8'h00, hl};
            4'hA: pattern_colour = {vl, vl, vl};
            4'hB: pattern_colour = {vl, 8'h00, 8'h00};
            4'hC: pattern_colour = {8'h00, vl, 8'h00};
            4'hD: pattern_colour = {8'h00, 8'h00, vl};
            default: pattern_colour = 24'h000000;
        endcase
    endfunction : pattern_colour

    assign en = ctrl_reg[vtpc_pkg::CTRL_ENABLE];
    assign tsel = cfg_reg[vtpc_pkg::CFG_TSEL];
    assign ind_rd = (index_reg < 8'(vtpc_pkg::IND_DEPTH)) ? ind_mem[index_reg[3:0]] : 8'h00;

    // Register writes.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= vtpc_pkg::PAT_CTRL_RST;
            cfg_reg <= vtpc_pkg::PAT_CFG_RST;
            index_reg <= vtpc_pkg::IND_INDEX_RST;
        end else if (reg_wr) begin
            if (reg_addr == vtpc_pkg::PAT_CTRL_OFS) begin
                ctrl_reg <= {reg_wdata[7:4], 3'b000, reg_wdata[0]};
            end else if (reg_addr == vtpc_pkg::PAT_CFG_OFS) begin
                cfg_reg <= {3'b000, reg_wdata[4:0]};
            end else if (reg_addr == vtpc_pkg::IND_INDEX_OFS) begin
                index_reg <= reg_wdata;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < vtpc_pkg::IND_DEPTH; i++) begin
                ind_mem[i] <= vtpc_pkg::IND_RST[i*8 +: 8];
            end
        end else if (reg_wr && (reg_addr == vtpc_pkg::IND_DATA_OFS) &&
            (index_reg < 8'(vtpc_pkg::IND_DEPTH))) begin
            ind_mem[index_reg[3:0]] <= reg_wdata;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == vtpc_pkg::PAT_CTRL_OFS) begin
                reg_rdata <= ctrl_reg;
            end else if (reg_addr == vtpc_pkg::PAT_CFG_OFS) begin
                reg_rdata <= cfg_reg;
            end else if (reg_addr == vtpc_pkg::IND_INDEX_OFS) begin
                reg_rdata <= index_reg;
            end else if (reg_addr == vtpc_pkg::IND_DATA_OFS) begin
                reg_rdata <= ind_rd;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    assign geom.htot = {ind_mem[vtpc_pkg::IND_HTOT+1][3:0], ind_mem[vtpc_pkg::IND_HTOT]};
    assign geom.vtot = {ind_mem[vtpc_pkg::IND_VTOT+1][3:0], ind_mem[vtpc_pkg::IND_VTOT]};
    assign geom.hact = {ind_mem[vtpc_pkg::IND_HACT+1][3:0], ind_mem[vtpc_pkg::IND_HACT]};
    assign geom.vact = {ind_mem[vtpc_pkg::IND_VACT+1][3:0], ind_mem[vtpc_pkg::IND_VACT]};
    assign geom.hsw = ind_mem[vtpc_pkg::IND_HSW];
    assign geom.vsw = ind_mem[vtpc_pkg::IND_VSW];
    assign geom.hbp = ind_mem[vtpc_pkg::IND_HBP];
    assign geom.vbp = ind_mem[vtpc_pkg::IND_VBP];
    assign geom.hs_pol = ind_mem[vtpc_pkg::IND_SYNC][0];
    assign geom.vs_pol = ind_mem[vtpc_pkg::IND_SYNC][1];
    assign pat_mask = {ind_mem[vtpc_pkg::IND_MASK+1], ind_mem[vtpc_pkg::IND_MASK]};

    // Host pins are synchronised first; edges are taken from the second stage onward.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_s1_reg <= 4'h0;
            pin_s2_reg <= 4'h0;
            pclk_d_reg <= 1'b0;
            vs_d_reg <= 1'b0;
        end else begin
            pin_s1_reg <= {pix_clk, pix_de, pix_hs, pix_vs};
            pin_s2_reg <= pin_s1_reg;
            pclk_d_reg <= pin_s2_reg[3];
            vs_d_reg <= pin_s2_reg[0];
        end
    end

    assign ext_tick = pin_s2_reg[3] && !pclk_d_reg;
    assign ext_sync = '{de: pin_s2_reg[2], hs: pin_s2_reg[1], vs: pin_s2_reg[0]};
    assign ext_frame = pin_s2_reg[0] && !vs_d_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_tick ? 8'h00 : 8'(div_reg + 8'h01);
        end
    end

    assign div_tick = (div_reg >= 8'(CLK_DIV - 1));
    // The clock source bit is only looked at under internal timing.
    assign tick = (tsel && !cfg_reg[vtpc_pkg::CFG_EXTCLK]) ?
        div_tick : ext_tick;

    vtpc_timing u_timing (
        .mclk(mclk),
        .rst(rst),
        .run(en && tsel),
        .tick(tick),
        .geom(geom),
        .sync_o(int_sync),
        .frame_start(int_frame),
        .hpos(int_h),
        .vpos(int_v)
    );

    // Positions under external timing are counted from data enable.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ext_h_reg <= 12'h000;
            ext_v_reg <= 12'h000;
            de_d_reg <= 1'b0;
        end else begin
            de_d_reg <= ext_sync.de;
            if (ext_frame) begin
                ext_v_reg <= 12'h000;
            end else if (de_d_reg && !ext_sync.de) begin
                ext_v_reg <= 12'(ext_v_reg + 12'h001);
            end
            if (!ext_sync.de) begin
                ext_h_reg <= 12'h000;
            end else if (ext_tick) begin
                ext_h_reg <= 12'(ext_h_reg + 12'h001);
            end
        end
    end

    assign cur_sync = tsel ? int_sync : ext_sync;
    assign frame_start = tsel ? int_frame : ext_frame;
    assign hpos = tsel ? int_h : ext_h_reg;
    assign vpos = tsel ? int_v : ext_v_reg;

    // A frame count of zero is treated as one so the scroll cannot stall.
    assign scroll_due = frame_start && en && cfg_reg[vtpc_pkg::CFG_SCROLL] &&
        (8'(frame_cnt_reg + 8'h01) >= ind_mem[vtpc_pkg::IND_FTC]);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cur_pat_reg <= vtpc_pkg::PAT_CTRL_RST[7:4];
            frame_cnt_reg <= 8'h00;
        end else if (!cfg_reg[vtpc_pkg::CFG_SCROLL]) begin
            cur_pat_reg <= ctrl_reg[7:4];
            frame_cnt_reg <= 8'h00;
        end else if (scroll_due) begin
            cur_pat_reg <= next_pattern(cur_pat_reg, pat_mask);
            frame_cnt_reg <= 8'h00;
        end else if (frame_start && en) begin
            frame_cnt_reg <= 8'(frame_cnt_reg + 8'h01);
        end
    end

    assign raw_colour = pattern_colour(cur_pat_reg, hpos[7:0], vpos[7:0]) &
        (cfg_reg[vtpc_pkg::CFG_BITS18] ? vtpc_pkg::MASK18 : 24'hFFFFFF);
    assign fin_colour = cfg_reg[vtpc_pkg::CFG_INVERT] ? ~raw_colour : raw_colour;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rgb_o <= 24'h000000;
            sync_o <= '0;
            pixel_strobe <= 1'b0;
        end else begin
            pixel_strobe <= tick && en;
            if (tick) begin
                rgb_o <= (en && cur_sync.de) ? fin_colour : 24'h000000;
                sync_o <= en ? cur_sync : '0;
            end
        end
    end

    sequence s_data_write;
        reg_wr && (reg_addr == vtpc_pkg::IND_DATA_OFS);
    endsequence

    a_disabled_dark: assert property (@(posedge mclk) disable iff (rst)
        tick && !en |=> (rgb_o == 24'h000000) && (sync_o == '0))
        else $error("output active while generator disabled");
    a_ext_follow: assert property (@(posedge mclk) disable iff (rst)
        tick && en && !tsel |=> sync_o == $past(ext_sync))
        else $error("external timing not followed");
    a_ext_ignore_clk: assert property (@(posedge mclk) disable iff (rst)
        !tsel |-> tick == ext_tick)
        else $error("clock source bit acted under external timing");
    a_int_clk_sel: assert property (@(posedge mclk) disable iff (rst)
        tsel |-> tick == (cfg_reg[vtpc_pkg::CFG_EXTCLK] ? ext_tick : div_tick))
        else $error("wrong pixel clock source under internal timing");
    a_colour_invert: assert property (@(posedge mclk) disable iff (rst)
        tick && en && cur_sync.de |=>
        rgb_o == ($past(cfg_reg[vtpc_pkg::CFG_INVERT]) ? ~$past(raw_colour) : $past(raw_colour)))
        else $error("colour inversion wrong");
    a_hold_fixed: assert property (@(posedge mclk) disable iff (rst)
        !cfg_reg[vtpc_pkg::CFG_SCROLL] ##1 !cfg_reg[vtpc_pkg::CFG_SCROLL] |->
        cur_pat_reg == $past(ctrl_reg[7:4]))
        else $error("pattern changed without auto-scroll");
    a_scroll_step: assert property (@(posedge mclk) disable iff (rst)
        scroll_due |=> cur_pat_reg == next_pattern($past(cur_pat_reg), $past(pat_mask)))
        else $error("auto-scroll did not advance");
    a_index_hold: assert property (@(posedge mclk) disable iff (rst)
        s_data_write or (reg_rd && (reg_addr == vtpc_pkg::IND_DATA_OFS)) |=> $stable(index_reg))
        else $error("indirect index moved on data access");
    a_data_write: assert property (@(posedge mclk) disable iff (rst)
        s_data_write and (index_reg < 8'(vtpc_pkg::IND_DEPTH)) |=> ind_rd == $past(reg_wdata))
        else $error("indirect write lost");
    a_data_read: assert property (@(posedge mclk) disable iff (rst)
        reg_rd && (reg_addr == vtpc_pkg::IND_DATA_OFS) |=> reg_rdata == $past(ind_rd))
        else $error("indirect read wrong");
endmodule : vtpc_top

/* testbench/vtpc_host_src.sv */
// Behavioural host parallel video source: pixel clock, data enable and both syncs.
// Assumes the bench raises run only while it wants host video traffic.
module vtpc_host_src #(
    parameter int HALF_NS = 80, // Half period of the host pixel clock.
    parameter int HTOT = 10, // Pixels per line.
    parameter int VTOT = 6, // Lines per frame.
    parameter int HACT = 6, // Active pixels per line.
    parameter int VACT = 4 // Active lines per frame.
) (
    input wire logic run, // Traffic runs while high.
    output logic pix_clk, // Host pixel clock.
    output logic de, // Data enable.
    output logic hs, // Horizontal sync.
    output logic vs // Vertical sync.
);
    timeunit 1ns;
    timeprecision 1ns;
    int h;
    int v;
    initial begin
        pix_clk = 1'b0;
        de = 1'b0;
        hs = 1'b0;
        vs = 1'b0;
        h = 0;
        v = 0;
        #3;
        forever begin
            if (run) begin
                #HALF_NS pix_clk = 1'b1;
                #HALF_NS pix_clk = 1'b0;
                // Pins move on the falling edge so they are settled at the next rise.
                de = (h < HACT) && (v < VACT);
                hs = (h == HACT + 1);
                vs = (v == VACT + 1);
                h = (h + 1) % HTOT;
                v = (h == 0) ? (v + 1) % VTOT : v;
            end else begin
                // Idle: the clock parks low and the pins never keep a stale value.
                pix_clk = 1'b0;
                de = ~de;
                hs = ~hs;
                vs = ~vs;
                #HALF_NS;
            end
        end
    end
endmodule : vtpc_host_src

/* testbench/tb_top.sv */
// Self-checking bench for the video test pattern control block.
// Assumes the default indirect geometry: 16x12 raster, 8x6 active, syncs 2 and 1, porches 2.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DIV = 4;
    localparam logic [7:0] A_CTRL = vtpc_pkg::PAT_CTRL_OFS;
    localparam logic [7:0] A_CFG = vtpc_pkg::PAT_CFG_OFS;
    localparam logic [7:0] A_IDX = vtpc_pkg::IND_INDEX_OFS;
    localparam logic [7:0] A_DAT = vtpc_pkg::IND_DATA_OFS;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic pix_clk, h_de, h_hs, h_vs;
    logic host_run = 1'b0;
    logic [23:0] rgb_o;
    vtpc_pkg::vtpc_sync_t sync_o;
    logic pixel_strobe;
    int fails = 0;
    int num_checks = 0;
    int seed = 32'h9785;
    int hc, vc;
    int ind[16];
    always #5 mclk = ~mclk;
    vtpc_top #(.CLK_DIV(DIV)) uut (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pix_clk(pix_clk),
        .pix_de(h_de), .pix_hs(h_hs), .pix_vs(h_vs), .rgb_o(rgb_o), .sync_o(sync_o),
        .pixel_strobe(pixel_strobe));
    vtpc_host_src host (.run(host_run), .pix_clk(pix_clk), .de(h_de), .hs(h_hs), .vs(h_vs));
    task automatic results();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        #1 d = reg_rdata;
    endtask : rd
    // Expected {de, hs, vs, colour} of raster position h, v for a fixed pattern.
    function automatic logic [26:0] pix(input int h, input int v, input int pat, input bit inv);
        logic de;
        logic [23:0] c;
        logic [7:0] x;
        de = h >= 4 && h < 12 && v >= 3 && v < 9;
        x = 8'(h - 4);
        case (pat)
            1: c = 24'hFFFFFF;
            3: c = 24'hFF0000;
            4: c = 24'h00FF00;
            5: c = 24'h0000FF;
            6: c = {x, x, x};
            default: c = 24'h000000;
        endcase
        c = inv ? ~c : c;
        return {de, 1'(h < 2), 1'(v < 1), de ? c : 24'h000000};
    endfunction : pix
    // Bounded wait for the next pixel strobe; gap counts the clock edges waited.
    task automatic wait_strobe(output int gap);
        gap = 0;
        do begin
            @(posedge mclk);
            #1 gap++;
        end while (pixel_strobe !== 1'b1 && gap < 200);
        if (gap >= 200) begin
            fails++;
            results();
        end
    endtask : wait_strobe
    task automatic start_int(input logic [7:0] cfg, input logic [7:0] ctrl);
        int gap;
        wr(A_CTRL, 8'h10);
        wr(A_CFG, cfg);
        wr(A_CTRL, ctrl);
        hc = 0;
        vc = 0;
        // Internal timing is two registers deep, so the first strobe still carries the
        // word of the stopped counters; pixel 0, 0 arrives with the second strobe.
        if (cfg[vtpc_pkg::CFG_TSEL]) wait_strobe(gap);
    endtask : start_int
    // Follows n strobes of the internal raster; pat 0 leaves the colour unchecked.
    task automatic run_int(input int n, input int pat, input bit inv, output logic [23:0] mid);
        int gap;
        logic [26:0] e;
        for (int k = 0; k < n; k++) begin
            wait_strobe(gap);
            if (k > 0) check("strobe gap", 24'(gap), 24'(DIV));
            e = pix(hc, vc, pat, inv);
            check("int sync", 24'(sync_o), 24'(e[26:24]));
            if (pat != 0) check("int rgb", rgb_o, e[23:0]);
            if (hc == 6 && vc == 5) mid = rgb_o;
            hc = (hc + 1) % 16;
            vc = (hc == 0) ? (vc + 1) % 12 : vc;
        end
    endtask : run_int
    task automatic host_clocked(input logic [7:0] cfg, input bit ext);
        int n;
        n = 0;
        start_int(cfg, 8'h11);
        repeat (640) begin
            @(posedge mclk);
            #1;
            if (pixel_strobe === 1'b1) begin
                n++;
                if (ext) check("ext sync", 24'(sync_o), {21'h0, h_de, h_hs, h_vs});
                if (ext) check("ext rgb", rgb_o, h_de ? 24'hFFFFFF : 24'h0);
            end
        end
        check("host ticks", 24'(n >= 39 && n <= 41), 24'h1);
    endtask : host_clocked
    initial begin
        logic [7:0] r, d;
        logic [23:0] mid, prev;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rd(A_CTRL, r);
        check("ctrl reset", 24'(r), 24'h10);
        rd(A_CFG, r);
        check("cfg reset", 24'(r), 24'h00);
        rd(A_IDX, r);
        check("index reset", 24'(r), 24'h00);
        wr(8'h70, 8'h5A);
        rd(8'h70, r);
        check("unmapped", 24'(r), 24'h00);
        wr(A_CTRL, 8'hFE);
        rd(A_CTRL, r);
        check("ctrl reserved", 24'(r), 24'hF0);
        wr(A_CFG, 8'hFF);
        rd(A_CFG, r);
        check("cfg reserved", 24'(r), 24'h1F);
        wr(A_CTRL, 8'h10);
        wr(A_CFG, 8'h04);
        repeat (40) begin
            @(posedge mclk);
            #1 check("disabled rgb", rgb_o, 24'h0);
            check("disabled sync", 24'(sync_o), 24'h0);
        end
        for (int i = 0; i < 16; i++) begin
            d = 8'($random(seed));
            ind[i] = int'(d);
            wr(A_IDX, 8'(i));
            wr(A_DAT, d);
            rd(A_DAT, r);
            check("indirect data", 24'(r), 24'(ind[i]));
            rd(A_IDX, r);
            check("indirect index", 24'(r), 24'(i));
            wr(A_DAT, vtpc_pkg::IND_RST[i*8 +: 8]);
            rd(A_DAT, r);
            check("indirect restore", 24'(r), 24'(vtpc_pkg::IND_RST[i*8 +: 8]));
        end
        // An index beyond the mapped space must neither store nor return data.
        wr(A_IDX, 8'h20);
        wr(A_DAT, 8'h55);
        rd(A_DAT, r);
        check("index beyond map", 24'(r), 24'h00);
        foreach (ind[p]) begin
            if (p inside {1, 3, 4, 5, 6}) begin
                start_int(8'h04, 8'(p << 4) | 8'h01);
                run_int(192, p, 1'b0, mid);
                start_int(8'h06, 8'(p << 4) | 8'h01);
                run_int(192, p, 1'b1, mid);
            end
        end
        // In 18-bit mode white loses its two low bits per colour before the inversion.
        start_int(8'h16, 8'h11);
        run_int(192, 0, 1'b0, mid);
        check("18-bit invert", mid, 24'h030303);
        host_run <= 1'b1;
        host_clocked(8'h0C, 1'b0);
        host_clocked(8'h00, 1'b1);
        host_clocked(8'h08, 1'b1);
        host_run <= 1'b0;
        wr(A_IDX, 8'h0E);
        wr(A_DAT, 8'h28);
        wr(A_IDX, 8'h0F);
        wr(A_DAT, 8'h00);
        start_int(8'h05, 8'h31);
        prev = 24'h0;
        for (int f = 0; f < 5; f++) begin
            // A fixed select of black written mid-run must not break the rotation.
            if (f == 2) wr(A_CTRL, 8'h21);
            run_int(192, 0, 1'b0, mid);
            // The rotation starts from the fixed select 1, so red and blue alternate.
            check("scroll colour", mid, f[0] ? 24'h0000FF : 24'hFF0000);
            if (f > 0) check("scroll step", 24'(mid != prev), 24'h1);
            prev = mid;
        end
        start_int(8'h04, 8'h31);
        repeat (3) run_int(192, 3, 1'b0, mid);
        results();
    end
endmodule : tb_top
